//--- bench/host_model.sv
// host controller model: link clock and wake register write
// assumes the link clock stands still between writes
`timescale 1ns/10ps
module host_model (
	output logic host_clk,
	output logic host_wake_write
);
	initial begin
		host_clk = 1'b0;
		host_wake_write = 1'b0;
	end
	// ==========
	// one write, clock runs only around it
	task automatic tick(input int n);
		repeat (n) begin
			#3 host_clk = 1'b1;
			#3 host_clk = 1'b0;
		end
	endtask
	task automatic send();
		#1.3;
		tick(2);
		host_wake_write = 1'b1;
		tick(1);
		host_wake_write = 1'b0;
		tick(4);
	endtask
endmodule // host_model

//--- bench/pwr_mgr_asserts.sv
// port relations of the power state manager
// assumes bind onto wlan_power_state_manager, one clk domain
`timescale 1ns/10ps
module pwr_mgr_asserts #(
	parameter int NB = 4,
	parameter int WW = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_powerdown_n,
	input wire logic [NB-1:0] clock_control,
	input wire logic [WW-1:0] wakeup_duration,
	input wire logic [2:0] power_state,
	input wire logic refclk_power_en,
	input wire logic pll_en,
	input wire logic sleep_clk_en,
	input wire logic [NB-1:0] block_clk_en,
	input wire logic [NB-1:0] block_power_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// wakeup entry and minimum stay
	sequence wake_entry;
		$changed(power_state) && power_state == 3'h3 && wakeup_duration >= 16'h0008;
	endsequence
	sequence wake_hold;
		(power_state == 3'h3) [*8];
	endsequence
	chk_off_quiet: assert property (power_state == 3'h0 |-> !sleep_clk_en && !refclk_power_en && !block_power_en)
		else $error("outputs active in off");
	chk_pd_priority: assert property ($fell(chip_powerdown_n) |-> ##[1:4] power_state == 3'h0)
		else $error("power-down not honoured");
	chk_sleep_gated: assert property (power_state == 3'h2 |-> !block_clk_en && !refclk_power_en && !pll_en)
		else $error("clock live in sleep");
	chk_wake_gated: assert property (power_state == 3'h3 |-> block_clk_en == '0)
		else $error("block clock live in wakeup");
	chk_on_enables: assert property (power_state == 3'h4 |-> (block_clk_en & ~clock_control) == '0)
		else $error("clock to disabled block");
	chk_host_domain: assert property (power_state == 3'h1 |-> block_power_en == 4'h4 && !refclk_power_en)
		else $error("host-only power wrong");
	chk_state_legal: assert property (power_state <= 3'h4)
		else $error("illegal power state");
	chk_sleep_exit: assert property (power_state == 3'h2 |=> power_state inside {3'h0, 3'h2, 3'h3})
		else $error("sleep left for wrong state");
	chk_wake_stay: assert property (disable iff (rst || !chip_powerdown_n) wake_entry |-> wake_hold)
		else $error("wakeup too short");
endmodule // pwr_mgr_asserts
bind wlan_power_state_manager pwr_mgr_asserts #(.NB(NB), .WW(WW)) chk (.clk, .rst, .chip_powerdown_n,
	.clock_control, .wakeup_duration, .power_state, .refclk_power_en, .pll_en, .sleep_clk_en,
	.block_clk_en, .block_power_en);

//--- bench/tb_wlan_power_state_manager.sv
// bench for the power state manager
// assumes host_model drives the host link
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("mismatch %s %h %h", nm, e, g); end end
module tb_wlan_power_state_manager;
	logic clk = 1'b0, rst = 1'b1, chip_powerdown_n = 1'b0, force_host_on_n = 1'b1, host_activity = 1'b0;
	logic mac_wake_event = 1'b0, low_freq_timer_event = 1'b0, gpio_irq = 1'b0, cpu_irq = 1'b0, cpu_halt = 1'b0;
	logic refclk_stable = 1'b0, ext_sleep_clk_sel = 1'b0, wlan_init_done = 1'b0, radio2_refclk_request = 1'b0;
	logic host_clk, host_wake_write, refclk_tick, refclk_power_en, pll_en, sleep_clk_en, sleep_clk_src_ext;
	logic cpu_run, radio2_refclk_en;
	logic [3:0] block_sleep_req = 4'h0, clock_control = 4'hB, block_clk_en, block_power_en, block_reset;
	logic [15:0] wakeup_duration = 16'h0010;
	logic [5:0] tick_cnt = 6'h00;
	logic [2:0] power_state;
	logic [7:0] ring_osc_trim;
	int fails = 0, n_compared = 0;
	wlan_power_state_manager uut (.*);
	host_model hm (.host_clk, .host_wake_write);
	always #2 clk = ~clk;
	always @(negedge clk) tick_cnt <= tick_cnt + 6'h01;
	assign refclk_tick = tick_cnt[5];
	// ==========
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_st(input logic [2:0] s);
		for (int i = 0; i < 400 && power_state !== s; i++) @(negedge clk);
		`CHK("state", s, power_state)
	endtask
	task automatic wrap_up();
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		cyc(6);
		rst = 1'b0;
		`CHK("trim", pwr_mgr_pkg::CAL_MID, ring_osc_trim)
		`CHK("resets", 4'hF, block_reset)
		cyc(2);
		chip_powerdown_n = 1'b1;
		wait_st(3'h1);
		`CHK("host_pwr", 4'h4, block_power_en)
		hm.send();
		wait_st(3'h3);
		cyc(40);
		`CHK("held", 3'h3, power_state)
		refclk_stable = 1'b1;
		wait_st(3'h4);
		`CHK("resets_rel", 4'h0, block_reset)
		`CHK("cpu_wait", 4'hA, block_clk_en)
		cpu_irq = 1'b1;
		cyc(6);
		`CHK("cpu_run", 1'b1, cpu_run)
		`CHK("clk_on", 4'hB, block_clk_en)
		cpu_irq = 1'b0;
		cpu_halt = 1'b1;
		cyc(6);
		`CHK("halt", 4'hA, block_clk_en)
		cpu_halt = 1'b0;
		radio2_refclk_request = 1'b1;
		cyc(6);
		`CHK("r2_early", 1'b0, radio2_refclk_en)
		wlan_init_done = 1'b1;
		ext_sleep_clk_sel = 1'b1;
		cyc(6);
		`CHK("r2_clk", 1'b1, radio2_refclk_en)
		`CHK("ext_clk", 1'b1, sleep_clk_src_ext)
		block_sleep_req = 4'h7;
		host_activity = 1'b1;
		cyc(20);
		`CHK("busy", 3'h4, power_state)
		for (int i = 0; i < 4; i++) begin
			host_activity = 1'b0;
			wait_st(3'h2);
			refclk_stable = 1'b0;
			`CHK("xo_off", 1'b0, refclk_power_en)
			{gpio_irq, low_freq_timer_event, mac_wake_event, host_activity} = 4'h1 << i;
			wait_st(3'h3);
			{gpio_irq, low_freq_timer_event, mac_wake_event, host_activity} = 4'h0;
			refclk_stable = 1'b1;
			wait_st(3'h4);
		end
		chip_powerdown_n = 1'b0;
		refclk_stable = 1'b0;
		cyc(4);
		`CHK("pd", 3'h0, power_state)
		`CHK("slp_clk", 1'b0, sleep_clk_en)
		force_host_on_n = 1'b0;
		cyc(2);
		chip_powerdown_n = 1'b1;
		wait_st(3'h3);
		wrap_up();
	end
	initial begin
		#100000;
		fails++;
		$display("mismatch watchdog 1 0");
		wrap_up();
	end
endmodule // tb_wlan_power_state_manager

//--- logic/pwr_mgr_pkg.sv
// power state manager constants and types
// assumes nothing beyond a SystemVerilog compiler
package pwr_mgr_pkg;
	localparam int NUM_BLOCKS = 4;
	localparam int WAKE_W = 16;
	localparam int CAL_W = 8;
	localparam logic [WAKE_W-1:0] WAKE_DEFAULT = 16'h0040;
	localparam logic [CAL_W-1:0] CAL_MID = 8'h80;
	localparam logic [1:0] BLK_CPU = 2'h0;
	localparam logic [1:0] BLK_MAC = 2'h1;
	localparam logic [1:0] BLK_HOST_MAILBOX = 2'h2;
	localparam logic [1:0] BLK_RADIO = 2'h3;
	localparam int CAL_WIN_W = 10;
	localparam logic [CAL_WIN_W-1:0] CAL_WIN = 10'h3FF;
	localparam logic [CAL_WIN_W-1:0] CAL_TARGET = 10'h00F;
	typedef enum logic [2:0] {
		st_off,
		st_host_only,
		st_sleep,
		st_wakeup,
		st_on
	} pwr_state_e;
endpackage

//--- logic/wlan_power_state_manager.sv
// always-on power and clock manager: five power states, clock and reset gating
// assumes clk is the sleep clock, host_clk the host link clock, refclk_stable from the oscillator
`timescale 1ns/10ps

module wlan_power_state_manager #(
	parameter int NB = pwr_mgr_pkg::NUM_BLOCKS,
	parameter int WW = pwr_mgr_pkg::WAKE_W,
	parameter int CW = pwr_mgr_pkg::CAL_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_clk,
	input wire logic chip_powerdown_n,
	input wire logic force_host_on_n,
	input wire logic host_wake_write,
	input wire logic host_activity,
	input wire logic [NB-1:0] block_sleep_req,
	input wire logic [NB-1:0] clock_control,
	input wire logic [WW-1:0] wakeup_duration,
	input wire logic mac_wake_event,
	input wire logic low_freq_timer_event,
	input wire logic gpio_irq,
	input wire logic cpu_irq,
	input wire logic cpu_halt,
	input wire logic refclk_stable,
	input wire logic refclk_tick,
	input wire logic ext_sleep_clk_sel,
	input wire logic wlan_init_done,
	input wire logic radio2_refclk_request,
	output logic [2:0] power_state,
	output logic refclk_power_en,
	output logic pll_en,
	output logic sleep_clk_en,
	output logic sleep_clk_src_ext,
	output logic [NB-1:0] block_clk_en,
	output logic [NB-1:0] block_power_en,
	output logic [NB-1:0] block_reset,
	output logic cpu_run,
	output logic radio2_refclk_en,
	output logic [CW-1:0] ring_osc_trim
);
	// ==========================================================
	// host clock domain
	// only the wake register lives here; the host clock may stand
	// still between accesses, so nothing level-sensitive is kept on it
	typedef struct packed {
		logic wake_tgl;
	} host_s;
	host_s h, next_h;

	// a write flips the toggle; the sleep side detects the edge
	// hazard avoided: a one-cycle pulse would be lost across domains
	always_comb begin
		next_h = h;
		if (host_wake_write) begin
			next_h.wake_tgl = ~h.wake_tgl;
		end
	end

	always_ff @(posedge host_clk or posedge rst) begin
		if (rst) begin
			h <= '0;
		end else begin
			h <= next_h;
		end
	end
	// ==========================================================
	// sleep clock domain
	typedef struct packed {
		pwr_mgr_pkg::pwr_state_e st;
		logic [1:0] pd_sync;
		logic pd_prev;
		logic [2:0] tgl_sync;
		logic [1:0] act_sync;
		logic [1:0] fho_sync;
		logic [1:0] stable_sync;
		logic [1:0] tick_sync;
		logic tick_prev;
		logic [1:0] mac_sync;
		logic [1:0] lft_sync;
		logic [1:0] gpio_sync;
		logic [1:0] irq_sync;
		logic [1:0] halt_sync;
		logic [1:0] init_sync;
		logic [1:0] r2req_sync;
		logic [1:0] ext_sync;
		logic [NB-1:0] idle_meta;
		logic [NB-1:0] idle_sync;
		logic [NB-1:0] ctl_meta;
		logic [NB-1:0] ctl_sync;
		logic [WW-1:0] dur_meta;
		logic [WW-1:0] dur_sync;
		logic [WW-1:0] wake_cnt;
		logic cpu_waiting;
		logic [pwr_mgr_pkg::CAL_WIN_W-1:0] cal_win;
		logic [pwr_mgr_pkg::CAL_WIN_W-1:0] cal_ticks;
		logic [2:0] power_state;
		logic refclk_power_en;
		logic pll_en;
		logic sleep_clk_en;
		logic sleep_clk_src_ext;
		logic [NB-1:0] block_clk_en;
		logic [NB-1:0] block_power_en;
		logic [NB-1:0] block_reset;
		logic cpu_run;
		logic radio2_refclk_en;
		logic [CW-1:0] trim;
	} core_s;
	core_s s, next_s;

	logic pd_asserted;
	logic host_wake;
	logic any_wake;
	logic all_idle;

	always_comb begin
		next_s = s;
		// two-flop crossings of every external level
		next_s.pd_sync = {s.pd_sync[0], ~chip_powerdown_n};
		next_s.tgl_sync = {s.tgl_sync[1:0], h.wake_tgl};
		// host activity is a pin level: crossed straight into the sleep clock,
		// since the host clock does not run while the link is idle
		next_s.act_sync = {s.act_sync[0], host_activity};
		next_s.fho_sync = {s.fho_sync[0], force_host_on_n};
		next_s.stable_sync = {s.stable_sync[0], refclk_stable};
		next_s.tick_sync = {s.tick_sync[0], refclk_tick};
		next_s.mac_sync = {s.mac_sync[0], mac_wake_event};
		next_s.lft_sync = {s.lft_sync[0], low_freq_timer_event};
		next_s.gpio_sync = {s.gpio_sync[0], gpio_irq};
		next_s.irq_sync = {s.irq_sync[0], cpu_irq};
		next_s.halt_sync = {s.halt_sync[0], cpu_halt};
		next_s.init_sync = {s.init_sync[0], wlan_init_done};
		next_s.r2req_sync = {s.r2req_sync[0], radio2_refclk_request};
		next_s.ext_sync = {s.ext_sync[0], ext_sleep_clk_sel};
		next_s.idle_meta = block_sleep_req;
		next_s.idle_sync = s.idle_meta;
		next_s.ctl_meta = clock_control;
		next_s.ctl_sync = s.ctl_meta;
		next_s.dur_meta = wakeup_duration;
		next_s.dur_sync = s.dur_meta;
		next_s.tick_prev = s.tick_sync[1];
		next_s.pd_prev = s.pd_sync[1];

		// ==========================================================
		// wake and idle decode
		// power-down level after the two-flop crossing
		pd_asserted = s.pd_sync[1];
		// toggle edge from the host domain: one cycle per host write
		host_wake = s.tgl_sync[2] ^ s.tgl_sync[1];
		// radio block bit is not a sleep condition
		any_wake = s.mac_sync[1] | s.act_sync[1] | s.lft_sync[1] | s.gpio_sync[1] | host_wake;
		all_idle = s.idle_sync[pwr_mgr_pkg::BLK_CPU] & s.idle_sync[pwr_mgr_pkg::BLK_MAC]
			& s.idle_sync[pwr_mgr_pkg::BLK_HOST_MAILBOX] & ~s.act_sync[1];

		// ==========================================================
		// state transitions; power-down has top priority
		if (pd_asserted) begin
			next_s.st = pwr_mgr_pkg::st_off;
		end else begin
			case (s.st)
				pwr_mgr_pkg::st_off: begin
					if (s.pd_prev) begin
						next_s.st = s.fho_sync[1] ? pwr_mgr_pkg::st_host_only : pwr_mgr_pkg::st_wakeup;
					end
				end
				pwr_mgr_pkg::st_host_only: begin
					if (host_wake) begin
						next_s.st = pwr_mgr_pkg::st_wakeup;
					end
				end
				pwr_mgr_pkg::st_sleep: begin
					if (any_wake) begin
						next_s.st = pwr_mgr_pkg::st_wakeup;
					end
				end
				pwr_mgr_pkg::st_wakeup: begin
					if (s.stable_sync[1] && s.wake_cnt >= s.dur_sync) begin
						next_s.st = pwr_mgr_pkg::st_on;
					end
				end
				pwr_mgr_pkg::st_on: begin
					if (all_idle) begin
						next_s.st = pwr_mgr_pkg::st_sleep;
					end
				end
				default: begin
					next_s.st = pwr_mgr_pkg::st_off;
				end
			endcase
		end

		// ==========================================================
		// wakeup duration counter on the sleep clock
		// saturates so a long wait for the reference never wraps
		if (s.st == pwr_mgr_pkg::st_wakeup) begin
			if (s.wake_cnt != '1) begin
				next_s.wake_cnt = s.wake_cnt + 1'b1;
			end
		end else begin
			next_s.wake_cnt = '0;
		end

		// cpu held after wake until an interrupt reaches it
		if (next_s.st == pwr_mgr_pkg::st_sleep || next_s.st == pwr_mgr_pkg::st_off
			|| next_s.st == pwr_mgr_pkg::st_host_only) begin
			next_s.cpu_waiting = 1'b1;
		end else if (s.irq_sync[1]) begin
			next_s.cpu_waiting = 1'b0;
		end

		// ==========================================================
		// ring oscillator calibration, only while on
		// window counted in sleep clocks, reference edges counted inside it
		if (s.st == pwr_mgr_pkg::st_on && !s.ext_sync[1]) begin
			next_s.cal_win = s.cal_win + 1'b1;
			if (s.tick_sync[1] && !s.tick_prev) begin
				next_s.cal_ticks = s.cal_ticks + 1'b1;
			end
			if (s.cal_win == pwr_mgr_pkg::CAL_WIN) begin
				next_s.cal_ticks = '0;
				if (s.cal_ticks > pwr_mgr_pkg::CAL_TARGET && s.trim != '1) begin
					next_s.trim = s.trim + 1'b1;
				end else if (s.cal_ticks < pwr_mgr_pkg::CAL_TARGET && s.trim != '0) begin
					next_s.trim = s.trim - 1'b1;
				end
			end
		end else begin
			next_s.cal_win = '0;
			next_s.cal_ticks = '0;
		end
		if (next_s.st == pwr_mgr_pkg::st_off) begin
			next_s.trim = pwr_mgr_pkg::CAL_MID;
		end

		// ==========================================================
		// registered outputs from the next state
		// decoded from next_s so outputs change with the state register
		next_s.power_state = 3'(next_s.st);
		next_s.refclk_power_en = next_s.st == pwr_mgr_pkg::st_wakeup
			|| next_s.st == pwr_mgr_pkg::st_on;
		next_s.pll_en = next_s.refclk_power_en;
		next_s.sleep_clk_en = next_s.st != pwr_mgr_pkg::st_off;
		next_s.sleep_clk_src_ext = s.ext_sync[1];
		next_s.block_power_en = '0;
		next_s.block_clk_en = '0;
		next_s.block_reset = '1;
		next_s.radio2_refclk_en = 1'b0;
		case (next_s.st)
			pwr_mgr_pkg::st_host_only: begin
				next_s.block_power_en[pwr_mgr_pkg::BLK_HOST_MAILBOX] = 1'b1;
				next_s.block_reset[pwr_mgr_pkg::BLK_HOST_MAILBOX] = 1'b0;
			end
			pwr_mgr_pkg::st_sleep, pwr_mgr_pkg::st_wakeup: begin
				next_s.block_power_en = '1;
				next_s.block_reset = s.block_reset;
			end
			pwr_mgr_pkg::st_on: begin
				next_s.block_power_en = '1;
				next_s.block_reset = '0;
				next_s.block_clk_en = s.ctl_sync;
				if (s.halt_sync[1]) begin
					next_s.block_clk_en[pwr_mgr_pkg::BLK_CPU] = 1'b0;
				end
				if (s.cpu_waiting) begin
					next_s.block_clk_en[pwr_mgr_pkg::BLK_CPU] = 1'b0;
				end
				next_s.radio2_refclk_en = s.init_sync[1] & s.r2req_sync[1];
			end
			default: begin
				next_s.block_power_en = '0;
			end
		endcase
		next_s.cpu_run = next_s.st == pwr_mgr_pkg::st_on && !next_s.cpu_waiting;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// reset looks like power-down held: a release edge is needed to leave off
			s <= '{
				st: pwr_mgr_pkg::st_off,
				block_reset: '1,
				trim: pwr_mgr_pkg::CAL_MID,
				pd_sync: 2'h3,
				pd_prev: 1'b1,
				cpu_waiting: 1'b1,
				default: '0
			};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign power_state = s.power_state;
	assign refclk_power_en = s.refclk_power_en;
	assign pll_en = s.pll_en;
	assign sleep_clk_en = s.sleep_clk_en;
	assign sleep_clk_src_ext = s.sleep_clk_src_ext;
	assign block_clk_en = s.block_clk_en;
	assign block_power_en = s.block_power_en;
	assign block_reset = s.block_reset;
	assign cpu_run = s.cpu_run;
	assign radio2_refclk_en = s.radio2_refclk_en;
	assign ring_osc_trim = s.trim;
endmodule // wlan_power_state_manager
